/* hw/swgpc_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------------
// constants of the pin control block
// ----------------------------------------------------------------------
package swgpc_pkg;
   localparam int unsigned NUM_PINS    = 4;
   localparam int unsigned WAKE_PINS   = 2;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned PIN_STRIDE  = 4;
   localparam int unsigned IN_POS      = 0;
   localparam int unsigned DIR_POS     = 1;
   localparam int unsigned VAL_POS     = 2;
   localparam int unsigned RSVD_POS    = 3;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [ADDR_W-1:0] GPC_OFFSET = 8'hb8;
   localparam logic       INPUT_RESET = 1'b1;
   localparam logic       DIR_RESET   = 1'b0;
   localparam logic       VAL_RESET   = 1'b0;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

/* hw/swgpc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// raw pin levels in, settled levels out
// ----------------------------------------------------------------------
interface swgpc_sync_if #(
   parameter int unsigned WIDTH = 4
);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] level;
   modport sync_side (input raw, output level);
   modport user_side (output raw, input level);
endinterface
`default_nettype wire

/* hw/swgpc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module swgpc_pin_sync #(
   parameter int unsigned WIDTH = swgpc_pkg::NUM_PINS
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   swgpc_sync_if.sync_side  bus
);
   import swgpc_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } swgpc_sync_state_t;

   swgpc_sync_state_t state;
   swgpc_sync_state_t next_state;

   // ----------------------------------------------------------------------
   // three stages, accept once stages two and three agree
   // ----------------------------------------------------------------------
   always_comb begin
      next_state       = state;
      next_state.s1    = bus.raw;
      next_state.s2    = state.s1;
      next_state.s3    = state.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (state.s2[i] == state.s3[i]) begin
            next_state.level[i] = state.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '{s1: {WIDTH{INPUT_RESET}}, s2: {WIDTH{INPUT_RESET}},
                    s3: {WIDTH{INPUT_RESET}}, level: {WIDTH{INPUT_RESET}}};
      end else begin
         state <= next_state;
      end
   end

   assign bus.level = state.level;

   level_settled_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state.level != $past(state.level)) |-> ($past(state.s2) == $past(state.s3)))
      else $error("level changed before synchroniser stages agreed");

endmodule // swgpc_pin_sync
`default_nettype wire

/* hw/swgpc_top.sv */
// What this block does
// - bit 0 reads pin 0 level, reset one
// - bit 1 sets pin 0 direction, reset input
// - bit 2 value driven on pin 0
// - pin 0 value needs port 1 wake off
// - pin 1 value needs port 2 wake off
// - pin 1 uses bits 4, 5, 6
// - pin 2 uses bits 8, 9, 10
// - pin 3 uses bits 12, 13, 14
// - wake enabled: port power sets pin value, oe stays with direction
`timescale 1ns/1ps
`default_nettype none
module swgpc_top (
   input  wire logic                          sys_clk,
   input  wire logic                          reset_n,
   input  wire logic [swgpc_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [swgpc_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [swgpc_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic [swgpc_pkg::WAKE_PINS-1:0] wake_cap_en,
   input  wire logic [swgpc_pkg::WAKE_PINS-1:0] port_power,
   input  wire logic [swgpc_pkg::NUM_PINS-1:0]  gpin_in,
   output logic      [swgpc_pkg::NUM_PINS-1:0]  gpin_out,
   output logic      [swgpc_pkg::NUM_PINS-1:0]  gpin_oe
);
   import swgpc_pkg::*;

   typedef struct packed {
      logic [NUM_PINS-1:0] dir;
      logic [NUM_PINS-1:0] val;
      logic [NUM_PINS-1:0] pin_out;
      logic [NUM_PINS-1:0] pin_oe;
      logic [DATA_W-1:0]   rdata;
   } swgpc_state_t;

   swgpc_state_t        state;
   swgpc_state_t        next_state;
   logic [DATA_W-1:0]   reg_view;
   logic                hit;
   logic [NUM_PINS-1:0] level;

   // ----------------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------------
   swgpc_sync_if #(.WIDTH(NUM_PINS)) sync_bus ();

   assign sync_bus.raw = gpin_in;

   swgpc_pin_sync #(.WIDTH(NUM_PINS)) u_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (sync_bus.sync_side)
   );

   // register view sees a pin change on the fourth edge after it
   assign level = sync_bus.level;
   assign hit   = (reg_addr == GPC_OFFSET);

   // ----------------------------------------------------------------------
   // register view
   // ----------------------------------------------------------------------
   always_comb begin
      reg_view = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         reg_view[PIN_STRIDE*i+IN_POS]   = level[i];
         reg_view[PIN_STRIDE*i+DIR_POS]  = state.dir[i];
         reg_view[PIN_STRIDE*i+VAL_POS]  = state.val[i];
         reg_view[PIN_STRIDE*i+RSVD_POS] = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // writes, pin drive, read data
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (reg_wr && hit) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            next_state.dir[i] = reg_wdata[PIN_STRIDE*i+DIR_POS];
            next_state.val[i] = reg_wdata[PIN_STRIDE*i+VAL_POS];
         end
      end
      next_state.pin_oe  = next_state.dir;
      next_state.pin_out = next_state.val;
      // wake override replaces the driven value only, oe stays with dir
      for (int i = 0; i < WAKE_PINS; i++) begin
         if (wake_cap_en[i]) begin
            next_state.pin_out[i] = port_power[i];
         end
      end
      next_state.rdata = (reg_rd && hit) ? reg_view : '0;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '{dir: {NUM_PINS{DIR_RESET}}, val: {NUM_PINS{VAL_RESET}},
                    pin_out: {NUM_PINS{VAL_RESET}}, pin_oe: {NUM_PINS{DIR_RESET}},
                    rdata: RDATA_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign gpin_out  = state.pin_out;
   assign gpin_oe   = state.pin_oe;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence gpc_wr_s;
      reg_wr && hit;
   endsequence

   sequence gpc_rd_s;
      reg_rd && hit;
   endsequence

   input_mirror_a: assert property (gpc_rd_s |=> reg_rdata[0] == $past(level[0]))
      else $error("pin 0 input bit does not mirror level");

   dir_pin0_a: assert property (gpc_wr_s |=> gpin_oe[0] == $past(reg_wdata[1]))
      else $error("pin 0 direction not applied");

   val_pin0_a: assert property ((gpc_wr_s and !wake_cap_en[0])
      |=> gpin_out[0] == $past(reg_wdata[2]))
      else $error("pin 0 value not driven");

   wake_pin0_a: assert property (wake_cap_en[0] |=> gpin_out[0] == $past(port_power[0]))
      else $error("pin 0 not driven by port power");

   wake_pin1_a: assert property (wake_cap_en[1] ##1 wake_cap_en[1]
      |=> gpin_out[1] == $past(port_power[1]) && $past(gpin_out[1]) == $past(port_power[1],2))
      else $error("pin 1 not driven by port power");

   pin1_fields_a: assert property ((gpc_wr_s and !wake_cap_en[1])
      |=> gpin_oe[1] == $past(reg_wdata[5]) && gpin_out[1] == $past(reg_wdata[6]))
      else $error("pin 1 fields not applied");

   pin2_fields_a: assert property (gpc_wr_s
      |=> gpin_oe[2] == $past(reg_wdata[9]) && gpin_out[2] == $past(reg_wdata[10]))
      else $error("pin 2 fields not applied");

   pin3_dir_a: assert property (gpc_wr_s |=> gpin_oe[3] == $past(reg_wdata[13]))
      else $error("pin 3 direction not applied");

   wake_release_a: assert property ((!wake_cap_en[0] && !reg_wr)[*2]
      |=> gpin_out[0] == $past(gpin_out[0]))
      else $error("pin 0 moved with no write and wake off");

   rsvd_zero_a: assert property (gpc_rd_s |=> !reg_rdata[3] && !reg_rdata[7]
      && !reg_rdata[11] && reg_rdata[31:15] == '0)
      else $error("reserved bits read non-zero");

   idle_rdata_a: assert property (!(reg_rd && hit) |=> reg_rdata == '0)
      else $error("read data outside read answer");

   // ----------------------------------------------------------------------
   // reset, read-back and hold checks
   // ----------------------------------------------------------------------

   // outputs are checked through reset as well
   reset_outputs_a: assert property (disable iff (1'b0)
      (!reset_n ##1 !reset_n) |-> gpin_oe == '0 && gpin_out == '0 && reg_rdata == '0)
      else $error("outputs not cleared in reset");

   // write, one quiet edge, read of the same word
   sequence gpc_wr_then_rd_s;
      gpc_wr_s ##1 !reg_wr ##1 gpc_rd_s;
   endsequence

   readback_a: assert property (gpc_wr_then_rd_s
      |=> (reg_rdata & 32'h0000_6666) == ($past(reg_wdata, 3) & 32'h0000_6666))
      else $error("direction or value bits not read back");

   wake_val0_a: assert property ((gpc_wr_s and wake_cap_en[0])
      |=> gpin_out[0] == $past(port_power[0]))
      else $error("pin 0 value bit leaked past wake");

   wake_val1_a: assert property ((gpc_wr_s and wake_cap_en[1])
      |=> gpin_out[1] == $past(port_power[1]))
      else $error("pin 1 value bit leaked past wake");

   pin3_val_a: assert property (gpc_wr_s |=> gpin_out[3] == $past(reg_wdata[14]))
      else $error("pin 3 value not driven");

   // direction moves only on a write that decodes
   oe_hold_a: assert property (!(reg_wr && hit) |=> gpin_oe == $past(gpin_oe))
      else $error("direction moved without a write");

   hi_out_hold_a: assert property (!reg_wr |=> gpin_out[3:2] == $past(gpin_out[3:2]))
      else $error("pin 2 or 3 value moved without a write");

   unmapped_rd_a: assert property ((reg_rd && !hit) |=> reg_rdata == '0)
      else $error("read of another offset returned data");

   // ----------------------------------------------------------------------
   // per pin checks
   // ----------------------------------------------------------------------

   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin_chk
      pin_dir_a: assert property (gpc_wr_s
         |=> gpin_oe[g] == $past(reg_wdata[PIN_STRIDE*g+DIR_POS]))
         else $error("pin direction not applied");

      rd_fields_a: assert property (gpc_rd_s
         |=> reg_rdata[PIN_STRIDE*g+IN_POS] == $past(level[g])
            && !reg_rdata[PIN_STRIDE*g+RSVD_POS])
         else $error("pin input bit does not mirror level");
   end

endmodule // swgpc_top
`default_nettype wire

/* sim/swgpc_board.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// board side of the pins
// ----------------------------------------------------------------------
module swgpc_board (
   input  wire logic [3:0] gpin_out,
   input  wire logic [3:0] gpin_oe,
   input  wire logic [3:0] board_level,
   output logic      [3:0] gpin_in
);
   // driven pin shows device value, else board level
   assign gpin_in = (gpin_oe & gpin_out) | (~gpin_oe & board_level);
endmodule // swgpc_board
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import swgpc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [1:0]  wake_cap_en = 2'h0;
   logic [1:0]  port_power = 2'h0;
   logic [3:0]  board_level = 4'hf;
   logic [3:0]  gpin_in, gpin_out, gpin_oe;
   int          failures = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #2 sys_clk = ~sys_clk;
   swgpc_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_cap_en(wake_cap_en), .port_power(port_power), .gpin_in(gpin_in),
      .gpin_out(gpin_out), .gpin_oe(gpin_oe));
   swgpc_board i_board (.gpin_out(gpin_out), .gpin_oe(gpin_oe),
      .board_level(board_level), .gpin_in(gpin_in));
   task test_done;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         test_done();
      end
   end
   task check32(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task check4(input string nm, input logic [3:0] e, input logic [3:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // write, let the pins settle through the synchroniser, read back
   task wr_rd(input logic [31:0] w, input logic [31:0] e, input string nm);
      logic [31:0] d;
      wr(GPC_OFFSET, w);
      repeat (6) @(posedge sys_clk);
      rd(GPC_OFFSET, d);
      check32(nm, e, d);
   endtask
   task t_reset;
      logic [31:0] d;
      #1 check4("oe reset", 4'h0, gpin_oe);
      check4("out reset", 4'h0, gpin_out);
      rd(GPC_OFFSET, d);
      check32("view reset", 32'h0000_1111, d);
      wr(8'hbc, 32'hffff_ffff);
      rd(8'hbc, d);
      check32("unmapped", 32'h0, d);
      check4("oe unmapped", 4'h0, gpin_oe);
   endtask
   task t_pins;
      wr_rd(32'hffff_ffff, 32'h0000_7777, "all ones");
      check4("oe on", 4'hf, gpin_oe);
      check4("out on", 4'hf, gpin_out);
      wr_rd(32'h0000_2222, 32'h0000_2222, "drive low");
      check4("out low", 4'h0, gpin_out);
      board_level <= 4'ha;
      wr_rd(32'h0000_0000, 32'h0000_1010, "inputs");
      check4("oe off", 4'h0, gpin_oe);
   endtask
   task t_wake;
      @(posedge sys_clk);
      wake_cap_en <= 2'h3;
      port_power <= 2'h1;
      wr(GPC_OFFSET, 32'h0000_0066);
      repeat (2) @(posedge sys_clk);
      port_power <= 2'h2;
      #1 check4("wake out", 4'h1, gpin_out);
      check4("wake oe", 4'h3, gpin_oe);
      repeat (2) @(posedge sys_clk);
      wake_cap_en <= 2'h0;
      #1 check4("power swap", 4'h2, gpin_out);
      repeat (2) @(posedge sys_clk);
      #1 check4("wake off", 4'h3, gpin_out);
   endtask
   // write then read straight away, reset in mid-run, synchroniser lag
   task t_midreset;
      logic [31:0] d;
      wr(GPC_OFFSET, 32'h0000_6666);
      rd(GPC_OFFSET, d);
      check32("pin 2 lag", 32'h0000_7677, d);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check4("oe midreset", 4'h0, gpin_oe);
      check4("out midreset", 4'h0, gpin_out);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(GPC_OFFSET, d);
      check32("sync from reset", 32'h0000_1111, d);
      repeat (4) @(posedge sys_clk);
      rd(GPC_OFFSET, d);
      check32("inputs after reset", 32'h0000_1010, d);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_pins();
      t_wake();
      t_midreset();
      test_done();
   end
endmodule // tb
`default_nettype wire
